//--- core_store_parity_addressing_tb_top.sv
// Self-checking bench for the core store access block
`timescale 1ns/100ps
module core_store_parity_addressing_tb_top;
    import cspa_pkg::*;
    typedef struct {
        logic [2:0] size;
        logic [14:0] addr;
        logic [15:0] data;
        logic prot;
    } cspa_row_s;
    cspa_row_s rows [8] = '{
        '{3'h0, 15'h7123, 16'hFFFF, 1'b0}, '{3'h1, 15'h6ABC, 16'h0001, 1'b1},
        '{3'h2, 15'h3456, 16'h8000, 1'b0}, '{3'h3, 15'h5040, 16'h1234, 1'b1},
        '{3'h4, 15'h6FFF, 16'h0000, 1'b0}, '{3'h5, 15'h7001, 16'hA5A5, 1'b1},
        '{3'h6, 15'h7FFF, 16'h00FF, 1'b0}, '{3'h7, 15'h2222, 16'h5555, 1'b1}};
    logic [11:0] rst_reg [5] = '{REG_CONFIG, REG_MASK, REG_STATUS, REG_ADDR, REG_DATA};
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [PADDR_W-1:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = '0;
    logic [1:0] go = 2'b00;
    logic [3:0] lag = 4'h0;
    logic c_we = 1'b0;
    logic [ADDR_W-1:0] c_addr = '0;
    logic [DATA_W-1:0] c_data = '0;
    logic c_prot = 1'b0;
    logic pready, pslverr, parity_err, irq, err;
    logic [31:0] prdata, rd;
    logic [WORD_W-1:0] rd_word, exp_w;
    wire [1:0] req, we, prot, ack, busy;
    wire [ADDR_W-1:0] a_int, a_ext;
    wire [DATA_W-1:0] d_int, d_ext;
    logic perr_seen = 1'b0;
    cspa_row_s r;
    logic [14:0] ea;
    int cyc = 0;
    int t0 = 0;
    int t_ack [2] = '{0, 0};
    int miscompares = 0;
    int comparisons = 0;

    cspa_core uut (.core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .int_req(req[0]), .int_we(we[0]),
        .int_addr(a_int), .int_wdata(d_int), .int_wprot(prot[0]), .int_ack(ack[0]),
        .ext_req(req[1]), .ext_we(we[1]), .ext_addr(a_ext), .ext_wdata(d_ext),
        .ext_wprot(prot[1]), .ext_ack(ack[1]), .rd_word(rd_word),
        .parity_err(parity_err), .irq(irq));
    cspa_req_model int_model (.core_clk(core_clk), .go(go[0]), .lag(lag), .we_in(c_we),
        .addr_in(c_addr), .data_in(c_data), .prot_in(c_prot), .ack(ack[0]), .req(req[0]),
        .we(we[0]), .addr(a_int), .wdata(d_int), .wprot(prot[0]), .busy(busy[0]));
    cspa_req_model ext_model (.core_clk(core_clk), .go(go[1]), .lag(lag), .we_in(c_we),
        .addr_in(c_addr), .data_in(c_data), .prot_in(c_prot), .ack(ack[1]), .req(req[1]),
        .we(we[1]), .addr(a_ext), .wdata(d_ext), .wprot(prot[1]), .busy(busy[1]));

    always #12.5 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (ack[0] === 1'b1) t_ack[0] <= cyc;
        if (ack[1] === 1'b1) t_ack[1] <= cyc;
        if (rst_n && parity_err !== 1'b0) perr_seen <= 1'b1;
        if (cyc == 20000) begin
            miscompares++;
            stop_test();
        end
    end

    function automatic logic [2:0] emod(input logic [2:0] s, input logic [2:0] m);
        case (s)
            3'h0: emod = 3'h0;
            3'h1: emod = {2'b00, m[0]};
            3'h2: emod = (m[1:0] == 2'b11) ? 3'h2 : {1'b0, m[1:0]};
            3'h3: emod = {1'b0, m[1:0]};
            3'h4: emod = m[2] ? 3'h4 : m;
            3'h5: emod = (m[2:1] == 2'b11) ? {2'b10, m[0]} : m;
            3'h6: emod = (m == 3'h7) ? 3'h6 : m;
            default: emod = m;
        endcase
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic access(input logic [1:0] p, input logic w, input logic [14:0] a,
            input logic [15:0] d, input logic pr, input logic [3:0] l);
        c_we <= w;
        c_addr <= a;
        c_data <= d;
        c_prot <= pr;
        lag <= l;
        go <= p;
        @(posedge core_clk);
        go <= 2'b00;
        t0 = cyc;
        @(posedge core_clk);
        while ((busy & p) != 2'b00) @(posedge core_clk);
        repeat (CYC_CNT) @(posedge core_clk);
    endtask

    task automatic stop_test;
        if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        check("outputs", 32'h0, 32'({rd_word, parity_err, irq, ack, pready, pslverr}));
        foreach (rst_reg[k]) begin
            apb(1'b0, rst_reg[k], 32'h0);
            check("reset value", (k == 0) ? 32'h7 : 32'h0, rd);
            check("reset error", 32'h0, 32'(err));
        end
        for (int i = 0; i < 8; i++) begin
            r = rows[i];
            ea = {emod(r.size, r.addr[14:12]), r.addr[11:0]};
            exp_w = {r.prot, ~^{r.prot, r.data}, r.data};
            apb(1'b1, REG_CONFIG, 32'h7);
            access(2'b01, 1'b1, ea, r.data, r.prot, 4'(i % 4));
            check("written word", 32'(exp_w), 32'(rd_word));
            check("ack latency", 32'(6 + i % 4), 32'(t_ack[0] - t0));
            apb(1'b0, REG_ADDR, 32'h0);
            check("address register", 32'(ea), rd);
            apb(1'b1, REG_CONFIG, 32'(r.size));
            apb(1'b0, REG_CONFIG, 32'h0);
            check("size", 32'(r.size), rd);
            access(2'b10, 1'b0, r.addr, 16'h0, 1'b0, 4'h0);
            check("read word", 32'(exp_w), 32'(rd_word));
            apb(1'b0, REG_DATA, 32'h0);
            check("data register", 32'(exp_w), rd);
        end
        access(2'b11, 1'b0, 15'h2222, 16'h0, 1'b0, 4'h0);
        check("grant order", 32'h1, 32'(t_ack[1] < t_ack[0]));
        check("cycle spacing", 32'(CYC_CNT), 32'(t_ack[0] - t_ack[1]));
        apb(1'b0, REG_STATUS, 32'h0);
        check("status both paths", 32'h6, rd);
        apb(1'b1, REG_MASK, 32'h2);
        access(2'b10, 1'b0, 15'h2222, 16'h0, 1'b0, 4'h0);
        repeat (3) @(posedge core_clk);
        check("masked irq", 32'h0, 32'(irq));
        access(2'b01, 1'b0, 15'h2222, 16'h0, 1'b0, 4'h2);
        repeat (3) @(posedge core_clk);
        check("irq", 32'h1, 32'(irq));
        apb(1'b1, REG_STATUS, 32'h0);
        apb(1'b0, REG_STATUS, 32'h0);
        check("status", 32'h6, rd);
        repeat (3) @(posedge core_clk);
        check("irq cleared", 32'h0, 32'(irq));
        apb(1'b1, 12'h020, 32'hFFFFFFFF);
        check("unmapped write", 32'h1, 32'(err));
        apb(1'b0, 12'h020, 32'h0);
        check("unmapped read", 32'h1, {rd[30:0], err});
        check("parity flag", 32'h0, 32'(perr_seen));
        stop_test();
    end
endmodule // core_store_parity_addressing_tb_top

//--- cspa_core.sv
// Storage access controller: arbitration, address and data registers, APB
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/100ps
module cspa_core
    import cspa_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic int_req,
    input wire logic int_we,
    input wire logic [ADDR_W-1:0] int_addr,
    input wire logic [DATA_W-1:0] int_wdata,
    input wire logic int_wprot,
    output logic int_ack,
    input wire logic ext_req,
    input wire logic ext_we,
    input wire logic [ADDR_W-1:0] ext_addr,
    input wire logic [DATA_W-1:0] ext_wdata,
    input wire logic ext_wprot,
    output logic ext_ack,
    output logic [WORD_W-1:0] rd_word,
    output logic parity_err,
    output logic irq
);
    cspa_state_e state;
    logic [CNT_W-1:0] cyc_cnt;
    logic [ADDR_W-1:0] s_reg;
    logic [WORD_W-1:0] z_reg;
    logic op_we;
    logic op_ext;
    logic [MOD_W-1:0] size_code;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic [EV_W-1:0] rd_snap;
    logic grant;
    logic grant_ext;
    logic [ADDR_W-1:0] req_addr;
    logic [MOD_W-1:0] eff_mod;
    logic [WORD_W-1:0] mem_rdata;
    logic gen_par;
    logic setup_ph;
    logic access_done;
    logic [EV_W-1:0] events;
    logic [31:0] next_prdata;
    logic next_slverr;

    assign grant_ext = ext_req;
    assign grant = (state == ST_IDLE) && (ext_req || int_req);
    assign req_addr = grant_ext ? ext_addr : int_addr;

    cspa_map u_map (
        .size_code(size_code),
        .mod_in(req_addr[ADDR_W-1:OFS_W]),
        .mod_out(eff_mod)
    );

    // Odd parity over protect and data
    assign gen_par = ~^{z_reg[PROT_BIT], z_reg[DATA_W-1:0]};

    cspa_mem u_mem (
        .core_clk(core_clk),
        .en(state == ST_ACCESS),
        .we(op_we),
        .addr(s_reg),
        .wdata({z_reg[PROT_BIT], gen_par, z_reg[DATA_W-1:0]}),
        .rdata(mem_rdata)
    );

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            cyc_cnt <= '0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (grant) begin
                        state <= ST_ACCESS;
                        cyc_cnt <= CNT_W'(CYC_CNT - 1);
                    end
                end
                ST_ACCESS: begin
                    state <= ST_LOAD;
                    cyc_cnt <= cyc_cnt - 1'b1;
                end
                ST_LOAD: begin
                    state <= ST_CHECK;
                    cyc_cnt <= cyc_cnt - 1'b1;
                end
                ST_CHECK: begin
                    state <= ST_RECOVER;
                    cyc_cnt <= cyc_cnt - 1'b1;
                end
                ST_RECOVER: begin
                    cyc_cnt <= cyc_cnt - 1'b1;
                    if (cyc_cnt == CNT_W'(1)) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Address register held for the access
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_reg <= '0;
            op_we <= 1'b0;
            op_ext <= 1'b0;
        end else if (grant) begin
            s_reg <= {eff_mod, req_addr[OFS_W-1:0]};
            op_we <= grant_ext ? ext_we : int_we;
            op_ext <= grant_ext;
        end
    end

    // Shared data register for both paths
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            z_reg <= '0;
        end else if (grant && (grant_ext ? ext_we : int_we)) begin
            z_reg <= grant_ext ? {ext_wprot, 1'b0, ext_wdata} : {int_wprot, 1'b0, int_wdata};
        end else if (state == ST_ACCESS && op_we) begin
            // Parity set while word sits here
            z_reg[PAR_BIT] <= gen_par;
        end else if (state == ST_LOAD && !op_we) begin
            z_reg <= mem_rdata;
        end
    end

    assign rd_word = z_reg;

    // Answers and parity flag
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            int_ack <= 1'b0;
            ext_ack <= 1'b0;
            parity_err <= 1'b0;
        end else begin
            int_ack <= (state == ST_CHECK) && !op_ext;
            ext_ack <= (state == ST_CHECK) && op_ext;
            // Even count on read is an error
            parity_err <= (state == ST_CHECK) && !op_we && !(^z_reg);
        end
    end

    // APB slave: answer prepared in setup, pready in access
    assign setup_ph = psel && !penable;
    assign access_done = psel && penable && pready;

    always_comb begin
        next_prdata = 32'h0000_0000;
        next_slverr = 1'b0;
        unique case (paddr)
            REG_CONFIG: next_prdata = {29'h0, size_code};
            REG_STATUS: next_prdata = {29'h0, status};
            REG_MASK: next_prdata = {29'h0, mask};
            REG_ADDR: next_prdata = {17'h0, s_reg};
            REG_DATA: next_prdata = {14'h0, z_reg};
            default: next_slverr = 1'b1;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_ph) begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr <= next_slverr;
        end else if (access_done) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Software configuration
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            size_code <= SIZE_RESET;
            mask <= MASK_RESET;
        end else if (access_done && pwrite) begin
            if (paddr == REG_CONFIG) begin
                size_code <= pwdata[MOD_W-1:0];
            end
            if (paddr == REG_MASK) begin
                mask <= pwdata[EV_W-1:0];
            end
        end
    end

    // Sticky events; read clears only bits that were returned
    assign events = {
        (state == ST_CHECK) && op_ext,
        (state == ST_CHECK) && !op_ext,
        (state == ST_CHECK) && !op_we && !(^z_reg)
    };
    assign rd_snap = (access_done && !pwrite && paddr == REG_STATUS) ? prdata[EV_W-1:0] : '0;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            status <= '0;
            irq <= 1'b0;
        end else begin
            status <= (status & ~rd_snap) | events;
            irq <= |(status & mask);
        end
    end

    // Checks
    logic [CNT_W-1:0] gap_cnt;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            gap_cnt <= CNT_W'(CYC_CNT);
        end else if (grant) begin
            gap_cnt <= CNT_W'(1);
        end else if (gap_cnt != CNT_W'(CYC_CNT)) begin
            gap_cnt <= gap_cnt + 1'b1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_grant;
        grant;
    endsequence
    sequence s_answer;
        ##4 (int_ack || ext_ack) ##1 !(int_ack || ext_ack);
    endsequence
    sequence s_setup;
        psel && !penable;
    endsequence

    // Storage access steps
    property p_addr_hold;
        (state != ST_IDLE) && !$past(grant) |-> $stable(s_reg);
    endproperty
    property p_word_ofs;
        grant |=> s_reg[OFS_W-1:0] == $past(req_addr[OFS_W-1:0]);
    endproperty
    property p_wrap_installed;
        grant |=> s_reg[ADDR_W-1:OFS_W] <= $past(size_code);
    endproperty
    property p_full_map;
        grant && (size_code == 3'h7) |=> s_reg == $past(req_addr);
    endproperty
    property p_load_z;
        (state == ST_LOAD) && !op_we |=> z_reg == $past(mem_rdata);
    endproperty
    property p_perr;
        (state == ST_CHECK) && !op_we |=> parity_err == !$past(^z_reg);
    endproperty
    property p_prot_int;
        grant && !grant_ext && int_we |=> ##2 z_reg[PROT_BIT] == $past(int_wprot, 3);
    endproperty
    property p_prot_ext;
        grant && grant_ext && ext_we |=> ##2 z_reg[PROT_BIT] == $past(ext_wprot, 3);
    endproperty
    property p_priority;
        grant && ext_req && int_req |=> op_ext ##3 ext_ack && !int_ack;
    endproperty
    property p_z_idle_hold;
        (state == ST_IDLE) && !grant |=> $stable(z_reg);
    endproperty
    property p_z_write_hold;
        (state == ST_LOAD) && op_we |=> $stable(z_reg);
    endproperty

    // Cycle length, neither short nor long
    property p_cycle_floor;
        (state == ST_IDLE) && ($past(state) == ST_RECOVER) |-> gap_cnt == CNT_W'(CYC_CNT);
    endproperty
    property p_cycle_ceiling;
        (state == ST_RECOVER) |-> gap_cnt < CNT_W'(CYC_CNT);
    endproperty

    // Register bus and sticky status
    property p_size_write;
        access_done && pwrite && (paddr == REG_CONFIG)
            |=> size_code == $past(pwdata[MOD_W-1:0]);
    endproperty
    property p_event_sticky;
        (|events) |=> (status & $past(events)) == $past(events);
    endproperty
    property p_read_clear;
        (rd_snap != '0) && (events == '0) |=> (status & $past(rd_snap)) == '0;
    endproperty

    AST_ACK_TIMING: assert property (s_grant |-> s_answer)
        else $error("answer not four cycles after grant");
    AST_SPACING: assert property (grant |-> gap_cnt == CNT_W'(CYC_CNT))
        else $error("storage cycles closer than one cycle time");
    AST_ADDR_HOLD: assert property (p_addr_hold)
        else $error("address register changed during access");
    AST_WORD_OFS: assert property (p_word_ofs)
        else $error("word offset not kept");
    AST_WRAP_INSTALLED: assert property (p_wrap_installed)
        else $error("mapped module not installed");
    AST_FULL_MAP: assert property (p_full_map)
        else $error("32K mapping not identity");
    AST_LOAD_Z: assert property (p_load_z)
        else $error("read word not loaded into data register");
    AST_WRITE_PARITY: assert property (state == ST_CHECK && op_we |-> ^z_reg)
        else $error("written word has even parity");
    AST_PERR: assert property (p_perr)
        else $error("parity error flag wrong");
    AST_PROT_KEPT: assert property (p_prot_int)
        else $error("protect flag not stored");
    AST_PROT_EXT: assert property (p_prot_ext)
        else $error("external protect flag not stored");
    AST_PRIORITY: assert property (p_priority)
        else $error("external path not preferred");
    AST_IRQ: assert property (irq == $past(|(status & mask)))
        else $error("interrupt does not follow masked status");
    AST_CYCLE_FLOOR: assert property (p_cycle_floor)
        else $error("storage cycle ended early");
    AST_CYCLE_CEILING: assert property (p_cycle_ceiling)
        else $error("storage cycle ran long");
    AST_ACK_ONE: assert property (!(int_ack && ext_ack))
        else $error("both paths answered at once");
    AST_PERR_WITH_ACK: assert property (parity_err |-> (int_ack || ext_ack) && !op_we)
        else $error("parity flag without a read answer");
    AST_Z_IDLE_HOLD: assert property (p_z_idle_hold)
        else $error("data register changed while idle");
    AST_Z_WRITE_HOLD: assert property (p_z_write_hold)
        else $error("written word changed after parity was set");
    AST_APB_READY: assert property (s_setup |=> pready)
        else $error("no answer in the access phase");
    AST_APB_PULSE: assert property (access_done |=> !pready)
        else $error("answer held past the transfer");
    AST_APB_ERR_ZERO: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
        else $error("refused transfer returned data");
    AST_SIZE_WRITE: assert property (p_size_write)
        else $error("size code not written");
    AST_EVENT_STICKY: assert property (p_event_sticky)
        else $error("status event lost");
    AST_READ_CLEAR: assert property (p_read_clear)
        else $error("status bits not cleared by read");
endmodule // cspa_core

//--- cspa_map.sv
// Module wrap-around mapping for the installed storage size
`timescale 1ns/100ps
module cspa_map
    import cspa_pkg::*;
(
    input wire logic [MOD_W-1:0] size_code,
    input wire logic [MOD_W-1:0] mod_in,
    output logic [MOD_W-1:0] mod_out
);
    always_comb begin
        unique case (size_code)
            3'h0: mod_out = 3'h0;
            3'h1: mod_out = {2'h0, mod_in[0]};
            3'h2: mod_out = (mod_in[1:0] == 2'h3) ? 3'h2 : {1'b0, mod_in[1:0]};
            3'h3: mod_out = {1'b0, mod_in[1:0]};
            3'h4: mod_out = mod_in[2] ? 3'h4 : mod_in;
            3'h5: mod_out = (mod_in[2:1] == 2'h3) ? {2'h2, mod_in[0]} : mod_in;
            3'h6: mod_out = (mod_in == 3'h7) ? 3'h6 : mod_in;
            3'h7: mod_out = mod_in;
        endcase
    end
endmodule // cspa_map

//--- cspa_mem.sv
// Core storage array with registered read data
`timescale 1ns/100ps
module cspa_mem
    import cspa_pkg::*;
(
    input wire logic core_clk,
    input wire logic en,
    input wire logic we,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [WORD_W-1:0] wdata,
    output logic [WORD_W-1:0] rdata
);
    logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];

    always_ff @(posedge core_clk) begin
        if (en && we) begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (en) begin
            rdata <= mem[addr];
        end
    end
endmodule // cspa_mem

//--- cspa_pkg.sv
// Constants, register map and state type for the core store access block
// Overview of operation
// - A stored word is 18 bits: data 15..0, parity 16, protect 17.
// - Parity makes the count of ones over all 18 bits odd.
// - Protect bit one marks a protected program word, zero unprotected.
// - Address is 15 bits: low twelve pick word, top three pick module.
// - A missing module wraps to the same word inside an installed module.
// - Effective module follows the per-size wrap table for 4K through 32K.
// - Every read word is loaded into the 18-bit data register and checked.
// - Parity is generated from the data register and written with each word.
// - A 15-bit address register holds the location for the whole access.
// - Accesses start no closer than one 1.1 us storage cycle apart.
// - Internal and external paths both pass data through the data register.
// - Installed size supports every multiple of 4K from 4K to 32K.
package cspa_pkg;
    localparam int CLK_PERIOD_PS = 25000;
    localparam int CYCLE_TIME_PS = 1100000;
    localparam int CYC_CNT = (CYCLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 6;

    localparam int WORD_W = 18;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 15;
    localparam int PAR_BIT = 16;
    localparam int PROT_BIT = 17;
    localparam int OFS_W = 12;
    localparam int MOD_W = 3;

    localparam int PADDR_W = 12;
    localparam logic [11:0] REG_CONFIG = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_MASK = 12'h008;
    localparam logic [11:0] REG_ADDR = 12'h00C;
    localparam logic [11:0] REG_DATA = 12'h010;

    // Size code n means (n+1) modules of 4K installed
    localparam logic [2:0] SIZE_RESET = 3'h7;
    localparam logic [2:0] MASK_RESET = 3'h0;
    localparam int EV_PERR = 0;
    localparam int EV_INT_DONE = 1;
    localparam int EV_EXT_DONE = 2;
    localparam int EV_W = 3;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ACCESS,
        ST_LOAD,
        ST_CHECK,
        ST_RECOVER
    } cspa_state_e;
endpackage

//--- cspa_req_model.sv
// Requester model for one storage access path
`timescale 1ns/100ps
module cspa_req_model
    import cspa_pkg::*;
(
    input wire logic core_clk,
    input wire logic go,
    input wire logic [3:0] lag,
    input wire logic we_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] data_in,
    input wire logic prot_in,
    input wire logic ack,
    output logic req = 1'b0,
    output logic we = 1'b0,
    output logic [ADDR_W-1:0] addr = '0,
    output logic [DATA_W-1:0] wdata = '0,
    output logic wprot = 1'b0,
    output logic busy = 1'b0
);
    logic [3:0] wait_cnt = 4'h0;

    always @(posedge core_clk) begin
        if (go && !busy) begin
            busy <= 1'b1;
            wait_cnt <= lag;
        end else if (busy && !req && wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
        end else if (busy && !req) begin
            req <= 1'b1;
            we <= we_in;
            addr <= addr_in;
            wdata <= data_in;
            wprot <= prot_in;
        end else if (req && ack) begin
            // Released fields turn over so stale values never look valid
            req <= 1'b0;
            busy <= 1'b0;
            we <= ~we;
            addr <= ~addr;
            wdata <= ~wdata;
            wprot <= ~wprot;
        end
    end
endmodule // cspa_req_model
